// file: pwrmc_pkg.sv
// constants and types for the power reduction mode controller
package pwrmc_pkg;
  // register byte addresses
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_AUX = 5'h04;
  localparam logic [4:0] ADDR_CFG = 5'h08;
  localparam logic [4:0] ADDR_IEN = 5'h0c;
  localparam logic [4:0] ADDR_REN = 5'h10;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  // power mode field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  localparam logic [1:0] MODE_TPDOWN = 2'h3;
  // power_control_reg fields
  localparam int CTRL_BOI = 4;
  localparam int CTRL_BOPD = 5;
  // power_control_aux_reg fields
  localparam int AUX_CMPPD = 5;
  localparam int AUX_RTC_POWER_DOWN_BIT = 7;
  // configuration register fields
  localparam int CFG_WATCHDOG_CLOCK_SELECT = 0;
  localparam int CFG_XTAL = 1;
  localparam int CFG_RCSEL = 2;
  localparam int CFG_RTCEN = 3;
  localparam int CFG_CMPEN = 4;
  localparam int CFG_BOE = 5;
  localparam int CFG_RTCXT = 6;
  // interrupt_enable_reg0 global bit and interrupt source indices
  localparam int IEN_GIE = 7;
  localparam int INT_RTC = 3;
  localparam int INT_WDT = 4;
  localparam int INT_CMP = 5;
  localparam int INT_BO = 6;
  localparam int NUM_INT = 7;
  localparam int NUM_RST = 3;
  // status register fields
  localparam int STAT_WRST = 4;
  localparam int STAT_WINT = 5;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  // oscillator stability counts, in clocks
  localparam logic [10:0] OSC_XTAL_CLKS = 11'h400;
  localparam logic [10:0] OSC_RC_CLKS = 11'h100;
  typedef enum logic [1:0] {ST_NORMAL, ST_IDLE, ST_PDOWN, ST_OSCWAIT} pwrmc_state_t;
endpackage

// file: pwrmc_top.sv
// power reduction mode controller with avalon-mm register slave
// Function
// - mode field: 00 normal, 01 idle, 10 power-down
// - mode 11 also kills brownout and comparators
// - idle halts cpu, peripherals keep clock
// - idle ends on enabled interrupt or reset
// - power-down stops the oscillator unless the running rtc is clocked from it
// - listed interrupt sources and resets wake power-down
// - reset wakes only if that reset enabled
// - interrupt wakes only with own and global enable
// - rc oscillator off in power-down unless rc clock and rtc
// - restart oscillator, wait 1024 or 256 clocks
// - brownout detection stays on in power-down
// - watchdog runs in power-down when clock-select set
// - comparators stay on unless powered down, disabled
// - rtc and its crystal run unless rtc power-down
`timescale 1ns/1ps
module pwrmc_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [5:0] INT_REQ,
  input wire logic [1:0] RST_REQ,
  input wire logic BO_DET,
  output logic CPU_HALT,
  output logic PERIPH_CLK_EN,
  output logic SYS_CLK_EN,
  output logic OSC_EN,
  output logic RC_OSC_EN,
  output logic BO_DET_EN,
  output logic CMP_PWR_EN,
  output logic WDT_RUN,
  output logic RTC_RUN,
  output logic WAKE_RESET,
  output logic WAKE_INT
);
  import pwrmc_pkg::*;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // bus and register state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] ctrl_q, ctrl_d, aux_q, aux_d, cfg_q, cfg_d;
  logic [7:0] ien_q, ien_d, ren_q, ren_d;
  logic wrst_q, wrst_d, wint_q, wint_d;
  logic rd_take, wr_go;
  logic [7:0] stat;
  // mode state
  pwrmc_state_t st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  // input synchronisers
  logic [8:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  // derived wake terms
  logic bo_act, tpd, irq_hit, rst_hit;
  logic [NUM_INT-1:0] int_v, alive;
  logic [NUM_RST-1:0] rst_v;
  // output registers
  logic halt_d, pclk_d, sclk_d, osc_d, rc_d, bo_d, cmp_d, wdt_d, rtc_d, wr_d, wi_d;

  function automatic logic [31:0] rd_mux(input logic [4:0] a, input logic [7:0] c,
                                         input logic [7:0] x, input logic [7:0] f,
                                         input logic [7:0] ie, input logic [7:0] re,
                                         input logic [7:0] s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_CTRL: v = c;
      ADDR_AUX: v = x;
      ADDR_CFG: v = f;
      ADDR_IEN: v = ie;
      ADDR_REN: v = re;
      ADDR_STAT: v = s;
      default: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  // idle or power-down, the states a wake event can end
  function automatic logic asleep(input pwrmc_state_t s);
    return s == ST_IDLE || s == ST_PDOWN;
  endfunction

  // waitrequest drops for one cycle per request
  assign rd_take = AVS_READ & wait_q;
  assign wr_go = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
  assign stat = {2'h0, wint_q, wrst_q, 2'h0, st_q};

  // filtered input change counts when stages two and three agree
  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
      s3_q <= 9'h000;
      filt_q <= 9'h000;
    end else begin
      s1_q <= {BO_DET, RST_REQ, INT_REQ};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  // wake qualification
  always_comb begin
    tpd = ctrl_q[1:0] == MODE_TPDOWN;
    // brownout detector alive only when not in the 11 mode
    bo_act = filt_q[8] & BO_DET_EN;
    int_v = {bo_act & ctrl_q[CTRL_BOI], filt_q[5:0]};
    rst_v = {bo_act & ~ctrl_q[CTRL_BOI], filt_q[7:6]};
    alive = {NUM_INT{1'b1}};
    if (st_q == ST_PDOWN) begin
      alive[INT_WDT] = WDT_RUN;
      alive[INT_RTC] = RTC_RUN;
      alive[INT_CMP] = CMP_PWR_EN & ~tpd;
      alive[INT_BO] = ~tpd;
    end
    irq_hit = ien_q[IEN_GIE] & |(int_v & ien_q[6:0] & alive);
    rst_hit = |(rst_v & ren_q[NUM_RST-1:0]);
  end

  // mode sequencing
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_NORMAL: begin
        if (ctrl_q[1:0] == MODE_IDLE) begin
          st_d = ST_IDLE;
        end else if (ctrl_q[1]) begin
          st_d = ST_PDOWN;
        end
      end
      ST_IDLE: begin
        if (irq_hit | rst_hit) begin
          st_d = ST_NORMAL;
        end
      end
      ST_PDOWN: begin
        if (irq_hit | rst_hit) begin
          st_d = ST_OSCWAIT;
          cnt_d = cfg_q[CFG_XTAL] ? OSC_XTAL_CLKS : OSC_RC_CLKS;
        end
      end
      ST_OSCWAIT: begin
        cnt_d = cnt_q - 11'h001;
        if (cnt_q == 11'h001) begin
          st_d = ST_NORMAL;
        end
      end
      default: begin
        st_d = ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= ST_NORMAL;
      cnt_q <= 11'h000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // register file
  always_comb begin
    wait_d = ~(AVS_READ | AVS_WRITE) | ~wait_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    aux_d = aux_q;
    cfg_d = cfg_q;
    ien_d = ien_q;
    ren_d = ren_q;
    wrst_d = wrst_q;
    wint_d = wint_q;
    if (rd_take) begin
      rdata_d = rd_mux(AVS_ADDRESS, ctrl_q, aux_q, cfg_q, ien_q, ren_q, stat);
    end
    // hardware returns the mode field to normal on wake
    if (asleep(st_q) && (irq_hit | rst_hit)) begin
      ctrl_d[1:0] = MODE_NORMAL;
    end
    if (wr_go) begin
      case (AVS_ADDRESS)
        ADDR_CTRL: ctrl_d = AVS_WRITEDATA[7:0];
        ADDR_AUX: aux_d = AVS_WRITEDATA[7:0];
        ADDR_CFG: cfg_d = AVS_WRITEDATA[7:0];
        ADDR_IEN: ien_d = AVS_WRITEDATA[7:0];
        ADDR_REN: ren_d = {5'h00, AVS_WRITEDATA[NUM_RST-1:0]};
        ADDR_STAT: begin
          wrst_d = wrst_q & ~AVS_WRITEDATA[STAT_WRST];
          wint_d = wint_q & ~AVS_WRITEDATA[STAT_WINT];
        end
        default: begin
        end
      endcase
    end
    // a wake event wins over a clear in the same cycle
    if (asleep(st_q) && rst_hit) begin
      wrst_d = 1'b1;
    end
    if (asleep(st_q) && irq_hit) begin
      wint_d = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_q <= REG_RST;
      aux_q <= REG_RST;
      cfg_q <= REG_RST;
      ien_q <= REG_RST;
      ren_q <= REG_RST;
      wrst_q <= 1'b0;
      wint_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      aux_q <= aux_d;
      cfg_q <= cfg_d;
      ien_q <= ien_d;
      ren_q <= ren_d;
      wrst_q <= wrst_d;
      wint_q <= wint_d;
    end
  end

  // power and clock controls, aligned with the next state
  always_comb begin
    halt_d = st_d != ST_NORMAL;
    pclk_d = st_d == ST_NORMAL || st_d == ST_IDLE;
    sclk_d = st_d != ST_PDOWN;
    rtc_d = cfg_d[CFG_RTCEN] & ~(st_d == ST_PDOWN & aux_d[AUX_RTC_POWER_DOWN_BIT]);
    // crystal kept alive whenever the running rtc is clocked from it
    osc_d = sclk_d | (rtc_d & cfg_d[CFG_RTCXT]);
    rc_d = cfg_d[CFG_RCSEL] & (st_d != ST_PDOWN | cfg_d[CFG_RTCEN]);
    bo_d = cfg_d[CFG_BOE] & ~ctrl_d[CTRL_BOPD] & (ctrl_d[1:0] != MODE_TPDOWN);
    cmp_d = ~(st_d == ST_PDOWN & (ctrl_d[1:0] == MODE_TPDOWN
             | (aux_d[AUX_CMPPD] & ~cfg_d[CFG_CMPEN])));
    wdt_d = st_d != ST_PDOWN | cfg_d[CFG_WATCHDOG_CLOCK_SELECT];
    wr_d = asleep(st_q) & rst_hit;
    wi_d = asleep(st_q) & irq_hit & ~rst_hit;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CPU_HALT <= 1'b0;
      PERIPH_CLK_EN <= 1'b1;
      SYS_CLK_EN <= 1'b1;
      OSC_EN <= 1'b1;
      RC_OSC_EN <= 1'b0;
      BO_DET_EN <= 1'b0;
      CMP_PWR_EN <= 1'b1;
      WDT_RUN <= 1'b1;
      RTC_RUN <= 1'b0;
      WAKE_RESET <= 1'b0;
      WAKE_INT <= 1'b0;
    end else begin
      CPU_HALT <= halt_d;
      PERIPH_CLK_EN <= pclk_d;
      SYS_CLK_EN <= sclk_d;
      OSC_EN <= osc_d;
      RC_OSC_EN <= rc_d;
      BO_DET_EN <= bo_d;
      CMP_PWR_EN <= cmp_d;
      WDT_RUN <= wdt_d;
      RTC_RUN <= rtc_d;
      WAKE_RESET <= wr_d;
      WAKE_INT <= wi_d;
    end
  end

  assign AVS_WAITREQUEST = wait_q;
  assign AVS_READDATA = rdata_q;

  chk_mode_decode: assert property (
    st_q == ST_NORMAL && ctrl_q[1:0] == MODE_IDLE |=> st_q == ST_IDLE)
    else $error("idle code did not enter idle");
  chk_idle_clocks: assert property (
    st_q == ST_IDLE |-> CPU_HALT && PERIPH_CLK_EN && SYS_CLK_EN)
    else $error("idle clocking wrong");
  chk_idle_wake: assert property (
    st_q == ST_IDLE && (irq_hit || rst_hit) |=> st_q == ST_NORMAL ##0 !CPU_HALT)
    else $error("idle not left on wake");
  chk_pd_osc_stop: assert property (
    st_q == ST_PDOWN && !cfg_q[CFG_RTCXT] |-> !OSC_EN && !SYS_CLK_EN && !PERIPH_CLK_EN)
    else $error("oscillator running in power-down");
  chk_pd_gie_gate: assert property (
    st_q == ST_PDOWN && !ien_q[IEN_GIE] && !rst_hit |=> st_q == ST_PDOWN)
    else $error("woke without global enable");
  chk_pd_rst_gate: assert property (
    st_q == ST_PDOWN && (rst_v & ren_q[NUM_RST-1:0]) != 3'h0
      |=> st_q == ST_OSCWAIT ##0 WAKE_RESET)
    else $error("enabled reset did not wake");
  chk_osc_load: assert property (
    st_q == ST_PDOWN && st_d == ST_OSCWAIT |=>
      cnt_q == (cfg_q[CFG_XTAL] ? OSC_XTAL_CLKS : OSC_RC_CLKS) ##0 CPU_HALT)
    else $error("stability count not loaded");
  chk_osc_end: assert property (
    st_q == ST_OSCWAIT && cnt_q == 11'h002 |=> st_q == ST_OSCWAIT ##1 st_q == ST_NORMAL)
    else $error("stability count end wrong");
  chk_tpd_bo_off: assert property (
    ctrl_q[1:0] == MODE_TPDOWN |-> !BO_DET_EN)
    else $error("brownout alive in 11 mode");
  chk_rc_osc_off: assert property (
    st_q == ST_PDOWN && !(cfg_q[CFG_RCSEL] && cfg_q[CFG_RTCEN]) |-> !RC_OSC_EN)
    else $error("rc oscillator left on");
  chk_pd_bo_keep: assert property (
    st_q == ST_PDOWN && ctrl_q[1:0] == MODE_PDOWN && cfg_q[CFG_BOE]
      && !ctrl_q[CTRL_BOPD] |-> BO_DET_EN)
    else $error("brownout stopped in power-down");
  chk_pd_wdt_keep: assert property (
    st_q == ST_PDOWN && cfg_q[CFG_WATCHDOG_CLOCK_SELECT] |-> WDT_RUN)
    else $error("watchdog stopped");
  chk_pd_cmp_keep: assert property (
    st_q == ST_PDOWN && !tpd && !aux_q[AUX_CMPPD] |-> CMP_PWR_EN)
    else $error("comparators stopped");
  chk_pd_rtc_keep: assert property (
    st_q == ST_PDOWN && cfg_q[CFG_RTCEN] |-> RTC_RUN == !aux_q[AUX_RTC_POWER_DOWN_BIT])
    else $error("rtc run wrong");
  chk_pd_src_wake: assert property (
    st_q == ST_PDOWN && irq_hit |=> st_q == ST_OSCWAIT)
    else $error("enabled interrupt did not wake");

  cov_idle_int: cover property (st_q == ST_IDLE && irq_hit ##1 WAKE_INT);
  cov_pd_rst: cover property (st_q == ST_PDOWN && rst_hit ##1 st_q == ST_OSCWAIT);
  cov_osc_done: cover property (st_q == ST_OSCWAIT ##1 st_q == ST_NORMAL);
  cov_tpd: cover property (st_q == ST_PDOWN && tpd);
endmodule

// file: pwrmc_src_model.sv
// interrupt and reset source model driving the controller request levels
`timescale 1ns/1ps
module pwrmc_src_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic [5:0] int_set,
  input wire logic [1:0] rst_set,
  input wire logic bo_set,
  input wire logic wake_int,
  input wire logic wake_reset,
  output logic [5:0] int_req,
  output logic [1:0] rst_req,
  output logic bo_det
);
  // requests are levels, held until a wake or a clear
  always_ff @(posedge clk) begin
    if (clr || wake_int || wake_reset) begin
      int_req <= '0;
      rst_req <= '0;
      bo_det <= 1'b0;
    end else begin
      int_req <= int_req | int_set;
      rst_req <= rst_req | rst_set;
      bo_det <= bo_det | bo_set;
    end
  end
endmodule

// file: pwrmc_top_tb.sv
// self-checking bench for the power reduction mode controller
`timescale 1ns/1ps
module pwrmc_top_tb;
  import pwrmc_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, clr = 1, bo_set = 0;
  logic [4:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic [3:0] be = 4'h1;
  logic [5:0] int_set = '0, int_req;
  logic [1:0] rst_set = '0, rst_req, seen;
  logic bo, wreq, halt, pclk, sclk, osc, rco, boen, cmp, wdt, rtc, w_rst, w_int;
  int fail_count = 0, comparisons = 0, n;
  logic [6:0] rows [4] = '{7'b00_01111, 7'b01_11111, 7'b10_10001, 7'b11_10000};
  pwrmc_top i_pwrmc_top (.REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .INT_REQ(int_req), .RST_REQ(rst_req), .BO_DET(bo),
    .CPU_HALT(halt), .PERIPH_CLK_EN(pclk), .SYS_CLK_EN(sclk), .OSC_EN(osc),
    .RC_OSC_EN(rco), .BO_DET_EN(boen), .CMP_PWR_EN(cmp), .WDT_RUN(wdt), .RTC_RUN(rtc),
    .WAKE_RESET(w_rst), .WAKE_INT(w_int));
  pwrmc_src_model i_pwrmc_src_model (.clk(clk), .clr(clr), .int_set(int_set),
    .rst_set(rst_set), .bo_set(bo_set), .wake_int(w_int), .wake_reset(w_rst),
    .int_req(int_req),
    .rst_req(rst_req), .bo_det(bo));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    // request held until waitrequest is sampled low at a rising edge
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic src(input logic [5:0] i, input logic [1:0] r, input logic c);
    int_set <= i;
    rst_set <= r;
    clr <= c;
    @(posedge clk);
    int_set <= '0;
    rst_set <= '0;
    clr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wake(output int k);
    k = 0;
    seen = '0;
    do @(negedge clk); while (w_int !== 1'b1 && w_rst !== 1'b1 && ++k < 50);
    seen = {w_rst, w_int};
    k = 0;
    while (halt !== 1'b0 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    settle(1);
    chk({halt, pclk, sclk, osc, rco, boen, cmp, wdt, rtc, wreq}, 10'b0111001101);
    @(posedge clk);
    bus(0, ADDR_CTRL, 8'h00); chk(q, 32'h0);
    be <= 4'h0;
    bus(1, ADDR_IEN, 8'hff);
    be <= 4'h1;
    bus(0, ADDR_IEN, 8'h00); chk(q, 32'h0);
    bus(0, 5'h18, 8'h00); chk(q, 32'h0);
    bus(1, ADDR_CFG, 8'h22);
    bus(1, ADDR_REN, 8'h01);
    foreach (rows[i]) begin
      bus(1, ADDR_CTRL, {6'h0, rows[i][6:5]});
      settle(3);
      chk({halt, pclk, sclk, osc, boen}, rows[i][4:0]);
      @(posedge clk);
      bus(0, ADDR_STAT, 8'h00);
      chk(q[1:0], (rows[i][6:5] == 2'h3) ? 2'h2 : rows[i][6:5]);
      if (i > 0) begin
        src(6'h0, 2'h1, 1'b0);
        wake(n); chk(seen, 2'b10);
        bus(0, ADDR_CTRL, 8'h00); chk(q[1:0], 2'h0);
      end
    end
    bus(1, ADDR_REN, 8'h00);
    bus(1, ADDR_CTRL, 8'h02);
    src(6'h0, 2'h1, 1'b0);
    settle(20); chk(halt, 1'b1);
    @(posedge clk);
    src(6'h0, 2'h0, 1'b1);
    for (int j = 0; j < 2; j++) begin
      bus(1, ADDR_CFG, j ? 8'h20 : 8'h22);
      bus(1, ADDR_IEN, 8'h01);
      bus(1, ADDR_CTRL, 8'h02);
      src(6'h01, 2'h0, 1'b0);
      settle(20); chk(halt, 1'b1);
      @(posedge clk);
      bus(1, ADDR_IEN, 8'h81);
      wake(n); chk(seen, 2'b01);
      chk(n, j ? 32'd256 : 32'd1024);
    end
    bus(1, ADDR_CFG, 8'h32);
    bus(1, ADDR_IEN, 8'ha0);
    bus(1, ADDR_CTRL, 8'h03);
    src(6'h20, 2'h0, 1'b0);
    settle(20); chk({halt, boen, cmp}, 3'b100);
    @(posedge clk);
    bus(1, ADDR_IEN, 8'ha1);
    src(6'h01, 2'h0, 1'b0);
    wake(n); chk(seen, 2'b01);
    bus(1, ADDR_REN, 8'h01);
    for (int j = 0; j < 2; j++) begin
      bus(1, ADDR_CFG, j ? 8'h48 : 8'h0d);
      bus(1, ADDR_AUX, j ? 8'h20 : 8'h80);
      bus(1, ADDR_CTRL, 8'h02);
      settle(3);
      chk({rco, wdt, rtc, cmp, osc}, j ? 5'b00101 : 5'b11010);
      @(posedge clk);
      src(6'h0, 2'h1, 1'b0);
      wake(n); chk(n, 32'd256);
    end
    // brownout reset wakes power-down
    bus(1, ADDR_CFG, 8'h20);
    bus(1, ADDR_REN, 8'h04);
    bus(1, ADDR_CTRL, 8'h02);
    bo_set <= 1'b1;
    @(posedge clk);
    bo_set <= 1'b0;
    wake(n); chk(seen, 2'b10);
    chk(n, 32'd256);
    bus(0, ADDR_STAT, 8'h00); chk(q, 32'h30);
    bus(1, ADDR_STAT, 8'h30);
    bus(0, ADDR_STAT, 8'h00); chk(q, 32'h0);
    // brownout ignored in the 11 mode
    bus(1, ADDR_CTRL, 8'h03);
    bo_set <= 1'b1;
    @(posedge clk);
    bo_set <= 1'b0;
    settle(20); chk(halt, 1'b1);
    @(posedge clk);
    bus(1, ADDR_REN, 8'h05);
    src(6'h0, 2'h1, 1'b0);
    wake(n); chk(seen, 2'b10);
    // enabled interrupt ends idle with no stability wait
    bus(1, ADDR_CTRL, 8'h01);
    src(6'h01, 2'h0, 1'b0);
    wake(n); chk(seen, 2'b01);
    chk(n, 32'd0);
    // reset in mid-run from power-down
    bus(1, ADDR_CTRL, 8'h02);
    settle(3); chk(halt, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    clr <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clr <= 1'b0;
    settle(1);
    chk({halt, pclk, sclk, osc, rco, boen, cmp, wdt, rtc, wreq}, 10'b0111001101);
    @(posedge clk);
    bus(0, ADDR_CTRL, 8'h00); chk(q, 32'h0);
    print_verdict();
  end
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
endmodule
